// >>> pief_top.sv
// Peripheral interrupt enable and flag block with an AXI4-Lite slave.
// Assumes peripherals and the core interrupt logic run on aclk.
//
// Summary of operation
// R1: Enable register at 8Ch, eight read/write bits, zero after reset.
// R2: Peripheral request reaches processor only with group enable and source enable.
// R3: Flag register holds one flag per source, same positions as enables.
// R4: Flags set on their event regardless of individual or global enable.
// R5: Software should clear flags before setting their enables.
// R6: Without parallel port, software keeps enable bit 7 at zero.
// R7: Bits 7..0: parallel port, adc, rx, tx, sync serial, capcomp, timer2, timer1.
// R8: Adc flag sets on conversion done and holds until software clears it.
`timescale 1ns/100ps
`default_nettype none
`include "pief_defines.svh"

module pief_top
	import pief_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire pief_addr_t s_axi_awaddr,
	input  wire logic       s_axi_awvalid,
	output var  logic       s_axi_awready,
	input  wire pief_word_t s_axi_wdata,
	input  wire logic [3:0] s_axi_wstrb,
	input  wire logic       s_axi_wvalid,
	output var  logic       s_axi_wready,
	output var  logic [1:0] s_axi_bresp,
	output var  logic       s_axi_bvalid,
	input  wire logic       s_axi_bready,
	input  wire pief_addr_t s_axi_araddr,
	input  wire logic       s_axi_arvalid,
	output var  logic       s_axi_arready,
	output var  pief_word_t s_axi_rdata,
	output var  logic [1:0] s_axi_rresp,
	output var  logic       s_axi_rvalid,
	input  wire logic       s_axi_rready,
	input  wire logic       parallel_port_event,
	input  wire logic       adc_done_event,
	input  wire logic       serial_rx_level,
	input  wire logic       serial_tx_level,
	input  wire logic       sync_serial_event,
	input  wire logic       capcomp_one_event,
	input  wire logic       timer_two_match_event,
	input  wire logic       timer_one_ovf_event,
	input  wire logic       peripheral_group_enable,
	output var  logic       peripheral_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic pief_hit(input pief_addr_t addr, input pief_addr_t off);
		pief_hit = (addr[7:2] == off[7:2]);
	endfunction

	localparam pief_addr_t OFF_ENABLE = `PIEF_OFF_ENABLE;
	localparam pief_addr_t OFF_FLAGS  = `PIEF_OFF_FLAGS;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	pief_addr_t awaddr_r;
	pief_byte_t wdata_r;
	logic       wstrb0_r;
	logic       aw_full_r;
	logic       aw_full_nxt;
	logic       w_full_r;
	logic       w_full_nxt;
	logic       awready_r;
	logic       wready_r;
	logic       bvalid_r;
	logic       bvalid_nxt;
	logic [1:0] bresp_r;
	logic       arready_r;
	logic       rvalid_r;
	logic       rvalid_nxt;
	logic [1:0] rresp_r;
	pief_word_t rdata_r;
	logic       do_write;
	logic       do_read;
	logic       wr_enable;
	logic       wr_flags;
	pief_byte_t enable_r;
	pief_byte_t flags;
	pief_byte_t event_vec;
	pief_byte_t clear_mask;
	logic       irq_r;

	////////////////////////////////////////////////////////////////////////////////
	// Write channels: address and data accepted in either order

	assign do_write    = aw_full_r & w_full_r & ~bvalid_r;
	assign aw_full_nxt = do_write ? 1'b0 : (aw_full_r | (s_axi_awvalid & awready_r));
	assign w_full_nxt  = do_write ? 1'b0 : (w_full_r | (s_axi_wvalid & wready_r));
	assign bvalid_nxt  = do_write ? 1'b1 : (bvalid_r & ~s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awready_r <= ~aw_full_nxt;
			wready_r  <= ~w_full_nxt;
			bvalid_r  <= bvalid_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 8'h00;
		end else if (s_axi_awvalid && awready_r) begin
			awaddr_r <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_r  <= 8'h00;
			wstrb0_r <= 1'b0;
		end else if (s_axi_wvalid && wready_r) begin
			wdata_r  <= s_axi_wdata[7:0];
			wstrb0_r <= s_axi_wstrb[0];
		end
	end

	// Unmapped addresses answer SLVERR and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bresp_r <= `PIEF_RESP_OKAY;
		end else if (do_write) begin
			if (pief_hit(awaddr_r, OFF_ENABLE) || pief_hit(awaddr_r, OFF_FLAGS)) begin
				bresp_r <= `PIEF_RESP_OKAY;
			end else begin
				bresp_r <= `PIEF_RESP_SLVERR;
			end
		end
	end

	// Only byte lane 0 carries register bits
	assign wr_enable = do_write & wstrb0_r & pief_hit(awaddr_r, OFF_ENABLE);
	assign wr_flags  = do_write & wstrb0_r & pief_hit(awaddr_r, OFF_FLAGS);

	////////////////////////////////////////////////////////////////////////////////
	// Read channel

	assign do_read    = s_axi_arvalid & arready_r;
	assign rvalid_nxt = do_read ? 1'b1 : (rvalid_r & ~s_axi_rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r  <= rvalid_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_r <= 32'h0000_0000;
			rresp_r <= `PIEF_RESP_OKAY;
		end else if (do_read) begin
			if (pief_hit(s_axi_araddr, OFF_ENABLE)) begin
				rdata_r <= {24'h00_0000, enable_r};
				rresp_r <= `PIEF_RESP_OKAY;
			end else if (pief_hit(s_axi_araddr, OFF_FLAGS)) begin
				rdata_r <= {24'h00_0000, flags}; // see R3
				rresp_r <= `PIEF_RESP_OKAY;
			end else begin
				rdata_r <= 32'h0000_0000;
				rresp_r <= `PIEF_RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Enable register; bit 7 is stored as written, software owns keeping it clear

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_r <= `PIEF_RST_ENABLE; // see R1
		end else if (wr_enable) begin
			enable_r <= wdata_r; // see R1 see R6
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags: writing one clears a sticky flag; level flags ignore writes

	always_comb begin
		event_vec                        = 8'h00;
		event_vec[`PIEF_BIT_PARPORT]     = parallel_port_event; // see R7
		event_vec[`PIEF_BIT_ADC]         = adc_done_event; // see R8
		event_vec[`PIEF_BIT_SER_RX]      = serial_rx_level;
		event_vec[`PIEF_BIT_SER_TX]      = serial_tx_level;
		event_vec[`PIEF_BIT_SYNC_SER]    = sync_serial_event;
		event_vec[`PIEF_BIT_CAPCOMP]     = capcomp_one_event;
		event_vec[`PIEF_BIT_TIMER_TWO_MATCH]  = timer_two_match_event;
		event_vec[`PIEF_BIT_TIMER_ONE_OVF]    = timer_one_ovf_event;
	end

	assign clear_mask = wr_flags ? wdata_r : 8'h00;

	pief_flag_bank u_pief_flag_bank (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.event_in   (event_vec),
		.clear_mask (clear_mask),
		.flags      (flags)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Request to the processor; stale flags fire as soon as enabled

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= peripheral_group_enable & (|(flags & enable_r)); // see R2 see R5
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign s_axi_awready  = awready_r;
	assign s_axi_wready   = wready_r;
	assign s_axi_bvalid   = bvalid_r;
	assign s_axi_bresp    = bresp_r;
	assign s_axi_arready  = arready_r;
	assign s_axi_rvalid   = rvalid_r;
	assign s_axi_rdata    = rdata_r;
	assign s_axi_rresp    = rresp_r;
	assign peripheral_irq = irq_r;

endmodule // pief_top
`default_nettype wire

// >>> pief_defines.svh
// Offsets, field positions, reset values and bus codes of the
// peripheral interrupt enable and flag block.
// Assumes inclusion by bare name from every file that needs it.
`ifndef PIEF_DEFINES_SVH
`define PIEF_DEFINES_SVH

`define PIEF_ADDR_W          8
`define PIEF_OFF_ENABLE      8'h8c
`define PIEF_OFF_FLAGS       8'h0c
`define PIEF_RST_ENABLE      8'h00
`define PIEF_RST_FLAGS       8'h00

`define PIEF_BIT_PARPORT     7
`define PIEF_BIT_ADC         6
`define PIEF_BIT_SER_RX      5
`define PIEF_BIT_SER_TX      4
`define PIEF_BIT_SYNC_SER    3
`define PIEF_BIT_CAPCOMP     2
`define PIEF_BIT_TIMER_TWO_MATCH  1
`define PIEF_BIT_TIMER_ONE_OVF    0

// Flags that mirror a peripheral level and ignore software writes
`define PIEF_FLAG_LEVEL_MASK 8'h30

`define PIEF_RESP_OKAY       2'h0
`define PIEF_RESP_SLVERR     2'h2

`endif

// >>> pief_pkg.sv
// Types shared by the peripheral interrupt enable and flag block.
// Assumes nothing of its surroundings.
package pief_pkg;

	typedef logic [7:0]  pief_byte_t;
	typedef logic [31:0] pief_word_t;
	typedef logic [7:0]  pief_addr_t;

endpackage

// >>> pief_flag_bank.sv
// Peripheral interrupt flag storage.
// Assumes single-cycle event pulses from on-chip peripherals on aclk, and levels on bits 5 and 4.
`timescale 1ns/100ps
`default_nettype none
`include "pief_defines.svh"

module pief_flag_bank
	import pief_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire pief_byte_t event_in,
	input  wire pief_byte_t clear_mask,
	output var  pief_byte_t flags
);

	localparam pief_byte_t LEVEL_MASK = `PIEF_FLAG_LEVEL_MASK;

	pief_byte_t flags_r;
	pief_byte_t flags_nxt;

	// Setting ignores every enable; a set in the clearing cycle wins
	assign flags_nxt = (LEVEL_MASK & event_in)
		| (~LEVEL_MASK & ((flags_r & ~clear_mask) | event_in)); // see R4 see R8

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= `PIEF_RST_FLAGS;
		end else begin
			flags_r <= flags_nxt; // see R3
		end
	end

	assign flags = flags_r;

endmodule // pief_flag_bank
`default_nettype wire

// >>> pief_periph_model.sv
// Stand-in for the on-chip peripherals that raise interrupt events.
// Assumes the bench drives fire on aclk; bits 5 and 4 are held as levels.
`timescale 1ns/100ps
`default_nettype none

module pief_periph_model
	import pief_pkg::*;
(
	input  wire logic       aclk,
	input  wire pief_byte_t fire,
	output var  pief_byte_t ev
);
	// Registered so events move just after the edge, as a real peripheral would
	always_ff @(posedge aclk) begin
		ev <= fire;
	end
endmodule // pief_periph_model
`default_nettype wire

// >>> pief_top_sva.sv
// Checker of read answers and the request output of pief_top.
// Assumes a bind onto pief_top; aclk is the only clock.
`timescale 1ns/100ps
`default_nettype none

module pief_top_sva
	import pief_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire pief_addr_t s_axi_araddr,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire pief_word_t s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       peripheral_group_enable,
	input wire logic       peripheral_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic [5:0] ar_w = s_axi_araddr[7:2];

	chk_group_gate: assert property (
		!peripheral_group_enable |=> !peripheral_irq) else $error("irq without group enable");
	chk_enable_read: assert property (
		ar_take && ar_w == 6'h23 |=> s_axi_rvalid && s_axi_rresp == 2'h0) else $error("enable read");
	chk_flags_read: assert property (
		ar_take && ar_w == 6'h03 |=> s_axi_rvalid && s_axi_rresp == 2'h0) else $error("flags read");
	chk_bad_read: assert property (
		ar_take && ar_w != 6'h23 && ar_w != 6'h03 |=> s_axi_rresp == 2'h2) else $error("unmapped read");
	chk_rdata_width: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
	chk_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r hold");
	chk_ar_block: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("arready during read answer");
endmodule // pief_top_sva

bind pief_top pief_top_sva u_pief_top_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .peripheral_group_enable(peripheral_group_enable),
	.peripheral_irq(peripheral_irq));
`default_nettype wire

// >>> tb_top.sv
// Bench of pief_top: register access, flag setting and clearing, request output.
// Assumes nothing outside; it drives the bus and the peripheral events itself.
`timescale 1ns/100ps
`default_nettype none
`include "pief_defines.svh"

module tb_top
	import pief_pkg::*;
;
	logic       aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
	logic       arv = 1'b0, rry = 1'b0, grp = 1'b0, awr, wr_y, bv, arr, rv, irq;
	logic [1:0] bresp, rresp, resp;
	pief_addr_t awa = 8'h00, ara = 8'h00;
	pief_word_t wd = 32'h0, rd_d, d;
	pief_byte_t fire = 8'h00, ev, m;
	int         bad_count = 0, n_compared = 0;
	logic [3:0] ws = 4'h1;
	logic       rlate = 1'b0;

	pief_top u_pief_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_y), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.parallel_port_event(ev[7]), .adc_done_event(ev[6]), .serial_rx_level(ev[5]),
		.serial_tx_level(ev[4]), .sync_serial_event(ev[3]), .capcomp_one_event(ev[2]),
		.timer_two_match_event(ev[1]), .timer_one_ovf_event(ev[0]),
		.peripheral_group_enable(grp), .peripheral_irq(irq));
	pief_periph_model u_pief_periph_model (.aclk(aclk), .fire(fire), .ev(ev));

	initial forever #20 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input pief_word_t got, input pief_word_t exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input pief_addr_t a, input pief_word_t v);
		@(posedge aclk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr_y)
				wv <= 1'b0;
		end while (bv !== 1'b1);
		resp = bresp;
		bry <= 1'b0;
	endtask
	task automatic rd(input pief_addr_t a);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= !rlate;
		// A late rready makes the slave hold its answer for a cycle
		do begin
			@(posedge aclk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv === 1'b1 && rry !== 1'b1)
				rry <= 1'b1;
		end while (!(rv === 1'b1 && rry === 1'b1));
		d = rd_d;
		resp = rresp;
		rry <= 1'b0;
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// A hung handshake would otherwise stall the run for ever
	initial begin
		repeat (5000) @(posedge aclk);
		bad_count++;
		results;
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PIEF_OFF_ENABLE);
		chk(d, 32'h0);
		rd(`PIEF_OFF_FLAGS);
		chk(d, 32'h0);
		wr(`PIEF_OFF_ENABLE, 32'h7f);
		chk(32'(resp), 32'h0);
		rd(`PIEF_OFF_ENABLE);
		chk(d, 32'h7f);
		// Lane 0 masked: the write is answered but stores nothing
		ws <= 4'h0;
		wr(`PIEF_OFF_ENABLE, 32'hff);
		chk(32'(resp), 32'h0);
		ws <= 4'h1;
		rlate = 1'b1;
		rd(`PIEF_OFF_ENABLE);
		rlate = 1'b0;
		chk(d, 32'h7f);
		wr(8'h40, 32'hff);
		chk(32'(resp), 32'h2);
		rd(8'h40);
		chk(32'(resp), 32'h2);
		wr(`PIEF_OFF_FLAGS, 32'hff);
		for (int i = 0; i < 8; i++) begin
			m = 8'h01 << i;
			wr(`PIEF_OFF_ENABLE, 32'h0);
			grp <= 1'b1;
			fire <= m;
			@(posedge aclk);
			if (!m[5] && !m[4])
				fire <= 8'h00;
			rd(`PIEF_OFF_FLAGS);
			chk(d, 32'(m));
			chk(32'(irq), 32'h0);
			wr(`PIEF_OFF_FLAGS, 32'h0);
			wr(`PIEF_OFF_ENABLE, 32'(m));
			rd(`PIEF_OFF_FLAGS);
			chk(d, 32'(m));
			chk(32'(irq), 32'h1);
			grp <= 1'b0;
			rd(`PIEF_OFF_FLAGS);
			chk(d, 32'(m));
			chk(32'(irq), 32'h0);
			grp <= 1'b1;
			fire <= 8'h00;
			wr(`PIEF_OFF_FLAGS, 32'(m));
			rd(`PIEF_OFF_FLAGS);
			chk(d, 32'h0);
			chk(32'(irq), 32'h0);
		end
		// Reset in mid-run drops enables and a pending flag
		wr(`PIEF_OFF_ENABLE, 32'h55);
		fire <= 8'h01;
		repeat (2) @(posedge aclk);
		fire <= 8'h00;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PIEF_OFF_ENABLE);
		chk(d, 32'h0);
		rd(`PIEF_OFF_FLAGS);
		chk(d, 32'h0);
		chk(32'(irq), 32'h0);
		results;
	end
endmodule // tb_top
`default_nettype wire
